// ==== rtl/dpc_pkg.sv ====
package dpc_pkg;

    // port geometry
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int SEM_W  = 3;

    // mailbox locations
    localparam logic [15:0] MBOX_LEFT_ADDR  = 16'hfffe;
    localparam logic [15:0] MBOX_RIGHT_ADDR = 16'hffff;

    // pin timing at 50 MHz (20 ns period)
    localparam int CLK_PERIOD_NS = 20;
    // long enough for the busy pin to cross the two-flop sync before a strobe
    localparam int SETUP_NS      = 60;
    localparam int PULSE_NS      = 60;
    localparam int HOLD_NS       = 20;
    localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PULSE_CYC = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HOLD_CYC  = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W     = 4;

    // semaphore write data bits
    localparam logic [7:0] SEM_CLAIM   = 8'h00;
    localparam logic [7:0] SEM_RELEASE = 8'h01;

    // user command kinds
    typedef enum logic [1:0] {
        DPC_CMD_MEM_RD = 2'h0,
        DPC_CMD_MEM_WR = 2'h1,
        DPC_CMD_SEM_RD = 2'h2,
        DPC_CMD_SEM_WR = 2'h3
    } dpc_cmd_e;

    typedef struct packed {
        dpc_cmd_e          kind;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } dpc_req_s;

    // pins of one device port, driven by this controller
    typedef struct packed {
        logic              mem_sel_n;
        logic              second_port_select;
        logic              semaphore_select_n;
        logic              rw_n;
        logic              oe_n;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] dq_out;
        logic              dq_oe_n;
    } dpc_pins_s;

endpackage

// ==== rtl/dpc_port_ctrl.sv ====
`timescale 1ns/100ps
`default_nettype none
//
// Overview of operation
// [RULE_01] eight semaphores at address bits 2:0; written via bit 0, read on all.
// [RULE_02] semaphore access: memory select high, semaphore select low.
// [RULE_03] writing 0 to a free semaphore gives this port the token.
// [RULE_04] a 0 from the non-holder changes nothing visible.
// [RULE_05] holder writing 1 passes token to a pending opposite requester.
// [RULE_06] holder writing 1 with no pending request frees the flag.
// [RULE_07] a non-holder's 0 stays latched until release, then granted.
// [RULE_08] semaphore read value latched while select and enable stay low.
// [RULE_09] simultaneous requests for one free flag grant exactly one port.
// [RULE_10] right port writing FFFE raises the left mailbox flag.
// [RULE_11] left port access of FFFE with output enable low clears it.
// [RULE_12] left writing FFFF raises right flag; right reading FFFF clears it.
// [RULE_13] mailbox bytes remain ordinary storage.
// [RULE_14] same location at once: one proceeds, the other sees busy.
// [RULE_15] a write from the busy port is suppressed inside the device.
// [RULE_16] a controller may wait while its busy indication is active.
// [RULE_17] slave busy pin is a write inhibit input only.
// [RULE_18] master arbitration uses selects and addresses only.
// [RULE_19] keep address and select valid until busy settles, then write.
// [RULE_20] exactly one master per width-expanded array.
// [RULE_21] ports operate independently; no cross-port delay.
// [RULE_22] semaphores gate no hardware and add no wait states.
// [RULE_23] a port idles in standby when both selects are inactive.
//
// controller for one port of the two-port memory; instantiate once per side
module dpc_port_ctrl #(
    parameter int ADDR_W    = dpc_pkg::ADDR_W,
    parameter int DATA_W    = dpc_pkg::DATA_W,
    parameter bit LEFT_SIDE = 1'b1
) (
    input  wire logic              i_clk,
    input  wire logic              i_rst,
    // user side
    input  wire logic              i_req_valid,
    input  wire dpc_pkg::dpc_req_s i_req,
    input  wire logic              i_wait_on_busy,
    output logic                   o_req_ready,
    output logic                   o_rsp_valid,
    output logic [DATA_W-1:0]      o_rsp_data,
    output logic                   o_rsp_busy_seen,
    output logic                   o_sem_owned,
    output logic                   o_mailbox_flag,
    // device side
    output dpc_pkg::dpc_pins_s     o_pins,
    input  wire logic [DATA_W-1:0] i_dq,
    input  wire logic              i_busy_n,
    input  wire logic              i_mailbox_n
);
    ////////////////////////////////////////////////////////////////////////
    // synchronise device pins
    logic [DATA_W+1:0] pin_sync;

    // busy comes from the single master part of a widened array [RULE_20]
    dpc_sync #(.W(DATA_W + 2)) u_sync (
        .i_clk (i_clk),
        .i_rst (i_rst),
        .i_d   ({i_busy_n, i_mailbox_n, i_dq}),
        .o_q   (pin_sync)
    );

    logic              busy_s;
    logic [DATA_W-1:0] dq_s;
    assign busy_s         = ~pin_sync[DATA_W+1];
    assign dq_s           = pin_sync[DATA_W-1:0];
    // flag pin is active low; shown to the user active high
    assign o_mailbox_flag = ~pin_sync[DATA_W];

    ////////////////////////////////////////////////////////////////////////
    // access sequencer
    typedef enum logic [4:0] {
        ST_IDLE  = 5'b00001,
        ST_SETUP = 5'b00010,
        ST_PULSE = 5'b00100,
        ST_HOLD  = 5'b01000,
        ST_DONE  = 5'b10000
    } dpc_state_e;

    dpc_state_e          state_reg, state_next;
    dpc_pkg::dpc_req_s   req_reg, req_next;
    logic [3:0]          cnt_reg, cnt_next;
    logic [DATA_W-1:0]   rdata_reg, rdata_next;
    logic                busy_reg, busy_next;
    logic [7:0]          owned_reg, owned_next;

    logic is_sem;
    logic sem_owned_now;
    assign is_sem = req_reg.kind == dpc_pkg::DPC_CMD_SEM_RD ||
                    req_reg.kind == dpc_pkg::DPC_CMD_SEM_WR;
    assign sem_owned_now = owned_reg[req_reg.addr[2:0]];

    always_comb begin
        state_next  = state_reg;
        req_next    = req_reg;
        cnt_next    = cnt_reg;
        rdata_next  = rdata_reg;
        busy_next   = busy_reg;
        owned_next  = owned_reg;
        case (state_reg)
            ST_IDLE: begin
                if (i_req_valid) begin
                    req_next   = i_req;
                    cnt_next   = 4'(dpc_pkg::SETUP_CYC);
                    busy_next  = 1'b0;
                    state_next = ST_SETUP;
                end
            end
            // address and select settle before any write strobe
            ST_SETUP: begin
                if (busy_s && !is_sem) begin
                    busy_next = 1'b1;
                end
                if (cnt_reg > 4'h1) begin
                    cnt_next = cnt_reg - 4'h1;
                end else if (!(i_wait_on_busy && busy_s && !is_sem)) begin
                    // master busy has settled before write pulse [RULE_19]
                    // optionally stall while the other port holds it [RULE_16]
                    cnt_next   = 4'(dpc_pkg::PULSE_CYC);
                    state_next = ST_PULSE;
                end
            end
            ST_PULSE: begin
                if (busy_s && !is_sem) begin
                    busy_next = 1'b1;
                end
                if (cnt_reg > 4'h1) begin
                    cnt_next = cnt_reg - 4'h1;
                end else begin
                    // sample once near the end of the strobe [RULE_08]
                    rdata_next = dq_s;
                    cnt_next   = 4'(dpc_pkg::HOLD_CYC);
                    state_next = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (cnt_reg > 4'h1) begin
                    cnt_next = cnt_reg - 4'h1;
                end else begin
                    state_next = ST_DONE;
                end
            end
            ST_DONE: begin
                // semaphore reads of 0 on bit 0 mean this side holds it
                if (req_reg.kind == dpc_pkg::DPC_CMD_SEM_RD) begin
                    owned_next[req_reg.addr[2:0]] = ~rdata_reg[0]; // [RULE_03]
                end else if (req_reg.kind == dpc_pkg::DPC_CMD_SEM_WR &&
                             req_reg.wdata[0]) begin
                    // release; any pending opposite claim takes over [RULE_05]
                    owned_next[req_reg.addr[2:0]] = 1'b0;
                end
                state_next = ST_IDLE;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state_reg <= ST_IDLE;
            req_reg   <= '0;
            cnt_reg   <= 4'h0;
            rdata_reg <= '0;
            busy_reg  <= 1'b0;
            owned_reg <= 8'h00;
        end else begin
            state_reg <= state_next;
            req_reg   <= req_next;
            cnt_reg   <= cnt_next;
            rdata_reg <= rdata_next;
            busy_reg  <= busy_next;
            owned_reg <= owned_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin drive, registered so strobes are glitch free
    dpc_pkg::dpc_pins_s pins_reg, pins_next;
    logic               active;
    logic               strobe;
    logic               nxt_sem;
    logic               nxt_wr;

    // pins follow the request being taken, not the one before it
    assign active  = state_next == ST_SETUP || state_next == ST_PULSE ||
                     state_next == ST_HOLD;
    assign strobe  = state_next == ST_PULSE;
    assign nxt_sem = req_next.kind == dpc_pkg::DPC_CMD_SEM_RD ||
                     req_next.kind == dpc_pkg::DPC_CMD_SEM_WR;
    assign nxt_wr  = req_next.kind == dpc_pkg::DPC_CMD_MEM_WR ||
                     req_next.kind == dpc_pkg::DPC_CMD_SEM_WR;

    always_comb begin
        // standby: both selects inactive [RULE_23]
        pins_next                    = '0;
        pins_next.mem_sel_n          = 1'b1;
        pins_next.second_port_select = 1'b0;
        pins_next.semaphore_select_n = 1'b1;
        pins_next.rw_n               = 1'b1;
        pins_next.oe_n               = 1'b1;
        pins_next.dq_oe_n            = 1'b1;
        pins_next.addr               = req_next.addr;
        if (active) begin
            if (nxt_sem) begin
                pins_next.semaphore_select_n = 1'b0; // [RULE_02]
                // only the low three bits matter here [RULE_01]
                pins_next.addr = {{(ADDR_W-3){1'b0}}, req_next.addr[2:0]};
            end else begin
                // FFFE/FFFF used as plain storage too [RULE_13]
                pins_next.mem_sel_n          = 1'b0;
                pins_next.second_port_select = 1'b1;
            end
            if (nxt_wr) begin
                // semaphore writes carry the token bit only [RULE_01]
                pins_next.dq_out  = nxt_sem ?
                    (req_next.wdata[0] ? dpc_pkg::SEM_RELEASE
                                       : dpc_pkg::SEM_CLAIM)
                    : req_next.wdata;
                pins_next.dq_oe_n = 1'b0;
                pins_next.rw_n    = ~strobe;
            end else begin
                // output enable low on reads also clears our mailbox [RULE_11]
                pins_next.oe_n = ~strobe;
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            pins_reg                    <= '0;
            pins_reg.mem_sel_n          <= 1'b1;
            pins_reg.semaphore_select_n <= 1'b1;
            pins_reg.rw_n               <= 1'b1;
            pins_reg.oe_n               <= 1'b1;
            pins_reg.dq_oe_n            <= 1'b1;
        end else begin
            pins_reg <= pins_next;
        end
    end

    assign o_pins          = pins_reg;
    assign o_req_ready     = state_reg == ST_IDLE;
    assign o_rsp_valid     = state_reg == ST_DONE;
    assign o_rsp_data      = rdata_reg;
    // write may have been dropped by the device [RULE_15]
    assign o_rsp_busy_seen = busy_reg;
    assign o_sem_owned     = sem_owned_now;
endmodule
`default_nettype wire

// ==== rtl/dpc_sync.sv ====
`timescale 1ns/100ps
`default_nettype none
// two-flop synchroniser for pins arriving from the device
module dpc_sync #(
    parameter int W = 1
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst,
    input  wire logic [W-1:0] i_d,
    output logic      [W-1:0] o_q
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] meta_next;
    logic [W-1:0] q_reg;
    logic [W-1:0] q_next;

    always_comb begin
        meta_next = i_d;
        q_next    = meta_reg;
    end

    // reset to ones: the device's flags and busy pins idle high
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            meta_reg <= '1;
            q_reg    <= '1;
        end else begin
            meta_reg <= meta_next;
            q_reg    <= q_next;
        end
    end

    assign o_q = q_reg;
endmodule
`default_nettype wire

// ==== tb/dpc_checker.sv ====
`timescale 1ns/100ps
`default_nettype none
module dpc_checker (
    input wire logic               i_clk,
    input wire logic               i_rst,
    input wire logic               i_req_valid,
    input wire logic               i_wait_on_busy,
    input wire logic               o_req_ready,
    input wire logic               o_rsp_valid,
    input wire logic               o_mailbox_flag,
    input wire dpc_pkg::dpc_pins_s o_pins
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    ////////////////////////////////////////////////////////////////////////
    sem_space_a: assert property (!o_pins.semaphore_select_n |->
        o_pins.mem_sel_n && o_pins.addr[15:3] == 13'h0)
        else $error("semaphore access with memory select or high address");
    idle_pins_a: assert property (o_req_ready |-> o_pins.mem_sel_n
        && o_pins.semaphore_select_n && o_pins.dq_oe_n)
        else $error("pins not released while idle");
    strobe_setup_a: assert property ($fell(o_pins.rw_n) |->
        $stable(o_pins.addr) && $stable(o_pins.mem_sel_n)
        && !(o_pins.mem_sel_n && o_pins.semaphore_select_n))
        else $error("address or select not settled at write start");
    strobe_len_a: assert property ($fell(o_pins.rw_n) |->
        (!o_pins.rw_n && !o_pins.dq_oe_n)[*3] ##1 o_pins.rw_n)
        else $error("write pulse length wrong");
    strobe_hold_a: assert property (!o_pins.rw_n |=>
        $stable(o_pins.addr) && $stable(o_pins.dq_out))
        else $error("address or data moved during write pulse");
    rsp_time_a: assert property (i_req_valid && o_req_ready
        && !i_wait_on_busy |-> ##8 o_rsp_valid)
        else $error("response not eight cycles after take");
    cover property (!o_pins.semaphore_select_n && !o_pins.rw_n);
    cover property (!o_pins.mem_sel_n && !o_pins.oe_n);
    cover property ($rose(o_mailbox_flag));
endmodule
bind dpc_port_ctrl dpc_checker u_chk (.i_clk(i_clk), .i_rst(i_rst),
    .i_req_valid(i_req_valid), .i_wait_on_busy(i_wait_on_busy),
    .o_req_ready(o_req_ready), .o_rsp_valid(o_rsp_valid),
    .o_mailbox_flag(o_mailbox_flag), .o_pins(o_pins));
`default_nettype wire

// ==== tb/dpc_dev_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module dpc_dev_model (
    input wire dpc_pkg::dpc_pins_s i_pins [2],
    output logic [7:0]             o_dq [2],
    output logic                   o_busy_n [2],
    output logic                   o_mailbox_n [2]
);
    logic [7:0] mem [65536];
    logic [7:0] lat [2];
    logic [1:0] own [8];
    logic       req [2][8];
    logic       mb [2];
    logic       lose [2];
    logic       blk [2];
    initial begin
        mb = '{1'b0, 1'b0};
        lose = '{1'b0, 1'b0};
        blk = '{1'b0, 1'b0};
        lat = '{8'h00, 8'h00};
        for (int i = 0; i < 8; i++) begin
            own[i] = 2'h0;
            req[0][i] = 1'b1;
            req[1][i] = 1'b1;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic settle(input int s, input int a);
        if (own[a][s] && req[s][a]) own[a][s] = 1'b0;
        if (own[a] == 2'h0) begin
            if (!req[s][a]) own[a][s] = 1'b1;
            else if (!req[1-s][a]) own[a][1-s] = 1'b1;
        end
    endtask
    for (genvar s = 0; s < 2; s++) begin : g_side
        always @(posedge i_pins[s].rw_n) begin
            if (!i_pins[s].mem_sel_n && i_pins[s].second_port_select
                && !blk[s]) begin
                mem[i_pins[s].addr] = i_pins[s].dq_out;
                if (i_pins[s].addr == (s ? 16'hfffe : 16'hffff))
                    mb[1-s] = 1'b1;
            end
            if (!i_pins[s].semaphore_select_n) begin
                req[s][i_pins[s].addr[2:0]] = i_pins[s].dq_out[0];
                settle(s, int'(i_pins[s].addr[2:0]));
            end
        end
        // latched on the falling enable so a far-side write cannot tear a read
        always @(negedge i_pins[s].oe_n) begin
            if (!i_pins[s].semaphore_select_n)
                lat[s] = {8{!own[i_pins[s].addr[2:0]][s]}};
            else if (!i_pins[s].mem_sel_n) begin
                lat[s] = mem[i_pins[s].addr];
                if (i_pins[s].addr == (s ? 16'hffff : 16'hfffe))
                    mb[s] = 1'b0;
            end
        end
        // released bus shows the inverse so a stale value never passes
        assign o_dq[s] = i_pins[s].oe_n ? ~lat[s] : lat[s];
        // late arrival on a shared address loses; a tie goes either way
        always @(negedge i_pins[s].mem_sel_n) begin
            #1;
            if (!i_pins[1-s].mem_sel_n && !lose[1-s] &&
                i_pins[1-s].addr == i_pins[s].addr)
                lose[s] = 1'b1;
        end
        always @(posedge i_pins[s].mem_sel_n or posedge i_pins[1-s].mem_sel_n)
            lose[s] = 1'b0;
        // inhibit taken as the strobe starts, as a slave part sees it
        always @(negedge i_pins[s].rw_n) blk[s] = lose[s];
        assign o_busy_n[s] = !lose[s];
        assign o_mailbox_n[s] = !mb[s];
    end
endmodule
`default_nettype wire

// ==== tb/dpc_tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module dpc_tb_top;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic rv [2], rdy [2], rsp_v [2], own [2], mbf [2], bsy [2], mbx [2];
    logic wob [2], bsn [2];
    logic [7:0] rsp_d [2], dq [2];
    dpc_pkg::dpc_req_s  rq [2];
    dpc_pkg::dpc_pins_s pins [2];
    int n_fail = 0;
    int compares = 0;
    always #10 i_clk = ~i_clk;
    for (genvar s = 0; s < 2; s++) begin : g_port
        dpc_port_ctrl #(.LEFT_SIDE(s == 0)) u_dut (.i_clk(i_clk),
            .i_rst(i_rst), .i_req_valid(rv[s]), .i_req(rq[s]),
            .i_wait_on_busy(wob[s]), .o_req_ready(rdy[s]),
            .o_rsp_valid(rsp_v[s]), .o_rsp_data(rsp_d[s]),
            .o_rsp_busy_seen(bsn[s]), .o_sem_owned(own[s]),
            .o_mailbox_flag(mbf[s]), .o_pins(pins[s]), .i_dq(dq[s]),
            .i_busy_n(bsy[s]), .i_mailbox_n(mbx[s]));
    end
    dpc_dev_model u_dev (.i_pins(pins), .o_dq(dq), .o_busy_n(bsy),
        .o_mailbox_n(mbx));
    ////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] got, exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic op(input int s, input dpc_pkg::dpc_cmd_e k,
                      input logic [15:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge i_clk);
        #1;
        while (!rdy[s] && n < 50) begin
            @(posedge i_clk);
            #1;
            n++;
        end
        rv[s] = 1'b1;
        rq[s] = '{kind: k, addr: a, wdata: d};
        @(posedge i_clk);
        #1 rv[s] = 1'b0;
        while (!rsp_v[s] && n < 50) begin
            @(posedge i_clk);
            #1;
            n++;
        end
        if (n >= 50) begin
            n_fail++;
            stop_test();
        end
    endtask
    // flag pins pass a two-flop synchroniser before they show
    task automatic flag(input int s, input logic e);
        repeat (3) @(posedge i_clk);
        #1 chk("mailbox flag", {7'h0, mbf[s]}, {7'h0, e});
    endtask
    task automatic t_mem();
        fork
            op(0, dpc_pkg::DPC_CMD_MEM_WR, 16'h0001, 8'ha5);
            op(1, dpc_pkg::DPC_CMD_MEM_WR, 16'hfffd, 8'h5a);
        join
        fork
            op(0, dpc_pkg::DPC_CMD_MEM_RD, 16'hfffd, 8'h00);
            op(1, dpc_pkg::DPC_CMD_MEM_RD, 16'h0001, 8'h00);
        join
        chk("left read", rsp_d[0], 8'h5a);
        chk("right read", rsp_d[1], 8'ha5);
        $display("test memory done");
    endtask
    // right starts one cycle after left on the same address and loses
    task automatic t_busy();
        fork
            op(0, dpc_pkg::DPC_CMD_MEM_WR, 16'h0100, 8'h11);
            begin
                @(posedge i_clk);
                op(1, dpc_pkg::DPC_CMD_MEM_WR, 16'h0100, 8'h22);
            end
        join
        chk("left busy", {7'h0, bsn[0]}, 8'h00);
        chk("right busy", {7'h0, bsn[1]}, 8'h01);
        op(0, dpc_pkg::DPC_CMD_MEM_RD, 16'h0100, 8'h00);
        chk("inhibited", rsp_d[0], 8'h11);
        wob[1] = 1'b1;
        fork
            op(0, dpc_pkg::DPC_CMD_MEM_WR, 16'h0100, 8'h33);
            begin
                @(posedge i_clk);
                op(1, dpc_pkg::DPC_CMD_MEM_WR, 16'h0100, 8'h44);
            end
        join
        wob[1] = 1'b0;
        chk("stall busy", {7'h0, bsn[1]}, 8'h01);
        op(1, dpc_pkg::DPC_CMD_MEM_RD, 16'h0100, 8'h00);
        chk("after stall", rsp_d[1], 8'h44);
        $display("test busy done");
    endtask
    task automatic t_mbox();
        op(1, dpc_pkg::DPC_CMD_MEM_WR, 16'hfffe, 8'h3c);
        flag(0, 1'b1);
        op(0, dpc_pkg::DPC_CMD_MEM_RD, 16'hfffe, 8'h00);
        chk("left box", rsp_d[0], 8'h3c);
        flag(0, 1'b0);
        op(0, dpc_pkg::DPC_CMD_MEM_WR, 16'hffff, 8'hc3);
        flag(1, 1'b1);
        op(1, dpc_pkg::DPC_CMD_MEM_RD, 16'hffff, 8'h00);
        chk("right box", rsp_d[1], 8'hc3);
        flag(1, 1'b0);
        $display("test mailbox done");
    endtask
    task automatic t_sem();
        logic [3:0] sq [10];
        sq = '{4'h1, 4'h9, 4'h6, 4'h2, 4'hd, 4'h7, 4'ha, 4'hf, 4'h1, 4'h7};
        foreach (sq[i]) begin
            op(sq[i][3], dpc_pkg::DPC_CMD_SEM_WR, 16'h0007, {7'h0, sq[i][2]});
            op(0, dpc_pkg::DPC_CMD_SEM_RD, 16'h0007, 8'h00);
            op(1, dpc_pkg::DPC_CMD_SEM_RD, 16'h0007, 8'h00);
            chk("sem left", rsp_d[0], {8{sq[i][1]}});
            chk("sem right", rsp_d[1], {8{sq[i][0]}});
            chk("owned", {7'h0, own[0]}, {7'h0, !sq[i][1]});
        end
        op(0, dpc_pkg::DPC_CMD_SEM_WR, 16'hfff8, 8'hfe);
        op(0, dpc_pkg::DPC_CMD_SEM_RD, 16'h0007, 8'h00);
        op(1, dpc_pkg::DPC_CMD_SEM_RD, 16'h0000, 8'h00);
        chk("other sem", rsp_d[0], 8'hff);
        chk("sem zero", rsp_d[1], 8'hff);
        fork
            op(0, dpc_pkg::DPC_CMD_SEM_WR, 16'h0003, 8'h00);
            op(1, dpc_pkg::DPC_CMD_SEM_WR, 16'h0003, 8'h00);
        join
        fork
            op(0, dpc_pkg::DPC_CMD_SEM_RD, 16'h0003, 8'h00);
            op(1, dpc_pkg::DPC_CMD_SEM_RD, 16'h0003, 8'h00);
        join
        chk("one owner", rsp_d[0] ^ rsp_d[1], 8'hff);
        $display("test semaphore done");
    endtask
    initial begin
        rv = '{1'b0, 1'b0};
        wob = '{1'b0, 1'b0};
        rq = '{'0, '0};
        repeat (16) @(posedge i_clk);
        #1 i_rst = 1'b0;
        t_mem();
        t_busy();
        t_mbox();
        t_sem();
        stop_test();
    end
endmodule
`default_nettype wire
